// ---- rtl/slpm_defs.svh ----
// Offsets, field positions, reset values and bus codes of the strap decode and pin mux block
`ifndef SLPM_DEFS_SVH
`define SLPM_DEFS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define SLPM_IDX_VINV 6'h02
`define SLPM_IDX_PSAVE 6'h03
`define SLPM_IDX_PCFG 6'h10
`define SLPM_IDX_GPIO 6'h11
`define SLPM_IDX_STAT 6'h12

// ==========================================================
// Field positions
`define SLPM_VINV_EN_BIT 1
`define SLPM_PSAVE_SEL_BIT 2
`define SLPM_PCFG_KIND_LSB 0
`define SLPM_PCFG_PWR_BIT 4
`define SLPM_GPIO_OUT_LSB 0
`define SLPM_GPIO_DIR_LSB 8
`define SLPM_STAT_BUS_LSB 0
`define SLPM_STAT_BE_BIT 7
`define SLPM_STAT_STRAP_LSB 8
`define SLPM_STAT_BS_BIT 12
`define SLPM_STAT_GPIN_LSB 16
`define SLPM_STAT_RUN_BIT 24

// ==========================================================
// Reset values
`define SLPM_VINV_RST 8'h00
`define SLPM_PSAVE_RST 8'h00
`define SLPM_PCFG_RST 8'h00
`define SLPM_GPIO_DIR_RST 5'h00
`define SLPM_GPIO_OUT_RST 5'h00

// ==========================================================
// AXI4-Lite response codes
`define SLPM_RESP_OKAY 2'h0
`define SLPM_RESP_SLVERR 2'h2

`endif

// ---- rtl/slpm_pkg.sv ----
// Types of the strap decode and pin mux block
package slpm_pkg;

  // Host bus flavour chosen by the straps, one-hot
  typedef enum logic [6:0] {
    SLPM_HB_NONE       = 7'h01,
    SLPM_HB_SYNC_READY = 7'h02,
    SLPM_HB_SYNC_WAIT  = 7'h04,
    SLPM_HB_ASYNC_ONE  = 7'h08,
    SLPM_HB_ASYNC_TWO  = 7'h10,
    SLPM_HB_GEN_ONE    = 7'h20,
    SLPM_HB_GEN_TWO    = 7'h40
  } slpm_host_bus_t;

  // Panel kind held in the panel configuration register
  typedef enum logic [1:0] {
    SLPM_PK_MONO_PASSIVE  = 2'h0,
    SLPM_PK_COLOR_PASSIVE = 2'h1,
    SLPM_PK_COLOR_SHIFT2  = 2'h2,
    SLPM_PK_ACTIVE        = 2'h3
  } slpm_panel_kind_t;

  // Strap capture sequence, one-hot
  typedef enum logic [1:0] {
    SLPM_ST_CAPTURE = 2'h1,
    SLPM_ST_RUN     = 2'h2
  } slpm_phase_t;

  // Whole state of the block
  typedef struct packed {
    slpm_phase_t st;
    slpm_host_bus_t host_bus;
    logic big_endian;
    logic [3:0] strap_raw;
    logic bs_raw;
    logic [7:0] vinv_reg;
    logic [7:0] psave_reg;
    logic [7:0] pcfg_reg;
    logic [4:0] gpio_dir;
    logic [4:0] gpio_out;
    logic [4:0] gpio_in;
    logic awready;
    logic aw_held;
    logic [7:0] awaddr;
    logic wready;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pd_low;
    logic frame;
    logic line;
    logic shift;
    logic ctl;
    logic pwr;
    logic [2:0] mid_o;
    logic [2:0] mid_oe;
    logic top_o;
    logic top_oe;
    logic gp0_o;
    logic gp0_oe;
    logic video_inv;
    logic power_save;
  } slpm_state_t;

endpackage

// ---- rtl/slpm_top.sv ----
// Strap decode, host bus select and LCD pin mux with an AXI4-Lite register slave
// What this block does
// - Straps x000 pick sync ready bus, endian bit3
// - Straps x001 pick sync wait bus, endian bit3
// - Straps 1011 pick first async bus; 0011 reserved
// - Straps 1101 pick second async bus; 0101 reserved
// - Straps x111, bus start low: generic one
// - Straps 0111, bus start high: generic two
// - Mid data pins: active panel data or GPIO
// - Top data pin: data, GPIO or invert input
// - Control pin: display enable or backplane bias
// - Shift2 colour format drives second shift clock
// - Power and panel outputs low during reset
// - Register 03h bit 2 selects power-save pin
// - Register 02h bit 1 enables video invert, except for the active panel kind
// - Reset loads defaults, outputs go inactive
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "slpm_defs.svh"

module slpm_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Straps and bus start pin
  input wire logic [3:0] config_straps_i,
  input wire logic bus_start_n_i,
  // Timing generator side
  input wire logic [11:0] panel_data_i,
  input wire logic panel_frame_pulse_i,
  input wire logic panel_line_pulse_i,
  input wire logic panel_shift_clock_i,
  input wire logic panel_second_shift_clock_i,
  input wire logic display_enable_i,
  input wire logic backplane_bias_i,
  // Panel pins
  output logic [7:0] panel_data_low_o,
  input wire logic [2:0] panel_data_mid_i,
  output logic [2:0] panel_data_mid_o,
  output logic [2:0] panel_data_mid_oe_o,
  input wire logic panel_data_top_i,
  output logic panel_data_top_o,
  output logic panel_data_top_oe_o,
  input wire logic gp_io_zero_i,
  output logic gp_io_zero_o,
  output logic gp_io_zero_oe_o,
  output logic panel_frame_pulse_o,
  output logic panel_line_pulse_o,
  output logic panel_shift_clock_o,
  output logic panel_ctl_out_o,
  output logic panel_power_ctl_o,
  // Decoded functions
  output slpm_pkg::slpm_host_bus_t host_bus_o,
  output logic big_endian_o,
  output logic video_invert_o,
  output logic power_save_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ==========================================================
  // State and reset value
  slpm_pkg::slpm_state_t s_q;
  slpm_pkg::slpm_state_t s_d;

  localparam slpm_pkg::slpm_state_t RST_STATE = '{
    st: slpm_pkg::SLPM_ST_CAPTURE,
    host_bus: slpm_pkg::SLPM_HB_NONE,
    vinv_reg: `SLPM_VINV_RST,
    psave_reg: `SLPM_PSAVE_RST,
    pcfg_reg: `SLPM_PCFG_RST,
    gpio_dir: `SLPM_GPIO_DIR_RST,
    gpio_out: `SLPM_GPIO_OUT_RST,
    default: '0
  };

  // ==========================================================
  // Helpers
  // Byte-lane merge of a write word
  function automatic logic [31:0] slpm_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Strap code to host bus flavour; reserved codes give none
  function automatic slpm_pkg::slpm_host_bus_t slpm_decode(input logic [3:0] cfg,
                                                           input logic bs_n);
    slpm_pkg::slpm_host_bus_t hb;
    hb = slpm_pkg::SLPM_HB_NONE;
    case (cfg[2:0])
      3'h0: hb = slpm_pkg::SLPM_HB_SYNC_READY;
      3'h1: hb = slpm_pkg::SLPM_HB_SYNC_WAIT;
      3'h3: hb = cfg[3] ? slpm_pkg::SLPM_HB_ASYNC_ONE : slpm_pkg::SLPM_HB_NONE;
      3'h5: hb = cfg[3] ? slpm_pkg::SLPM_HB_ASYNC_TWO : slpm_pkg::SLPM_HB_NONE;
      3'h7: begin
        if (!bs_n) begin
          hb = slpm_pkg::SLPM_HB_GEN_ONE;
        end else if (!cfg[3]) begin
          hb = slpm_pkg::SLPM_HB_GEN_TWO;
        end else begin
          hb = slpm_pkg::SLPM_HB_NONE;
        end
      end
      default: hb = slpm_pkg::SLPM_HB_NONE;
    endcase
    return hb;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic rd_hit;
    logic active;
    wr_word = '0;
    rd_word = '0;
    rd_hit = 1'b1;
    s_d = s_q;
    active = (s_q.pcfg_reg[1:0] == slpm_pkg::SLPM_PK_ACTIVE);

    // Strap capture at the first edge after release, then frozen
    case (s_q.st)
      slpm_pkg::SLPM_ST_CAPTURE: begin
        s_d.strap_raw = config_straps_i;
        s_d.bs_raw = bus_start_n_i;
        s_d.host_bus = slpm_decode(config_straps_i, bus_start_n_i);
        s_d.big_endian = config_straps_i[3] &&
                         (s_d.host_bus != slpm_pkg::SLPM_HB_NONE) &&
                         (s_d.host_bus != slpm_pkg::SLPM_HB_GEN_TWO);
        s_d.st = slpm_pkg::SLPM_ST_RUN;
      end
      slpm_pkg::SLPM_ST_RUN: begin
        s_d.st = slpm_pkg::SLPM_ST_RUN;
      end
      default: begin
        s_d.st = slpm_pkg::SLPM_ST_CAPTURE;
      end
    endcase

    // Write address and data are taken in either order
    if (s_q.awready && s_axi_awvalid_i) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_q.wready && s_axi_wvalid_i) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end

    // Register write once both halves are held and no response waits
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `SLPM_RESP_OKAY;
      case (s_q.awaddr[7:2])
        `SLPM_IDX_VINV: begin
          wr_word = slpm_merge({24'h000000, s_q.vinv_reg}, s_q.wdata, s_q.wstrb);
          s_d.vinv_reg = wr_word[7:0];
        end
        `SLPM_IDX_PSAVE: begin
          wr_word = slpm_merge({24'h000000, s_q.psave_reg}, s_q.wdata, s_q.wstrb);
          s_d.psave_reg = wr_word[7:0];
        end
        `SLPM_IDX_PCFG: begin
          wr_word = slpm_merge({24'h000000, s_q.pcfg_reg}, s_q.wdata, s_q.wstrb);
          s_d.pcfg_reg = wr_word[7:0];
        end
        `SLPM_IDX_GPIO: begin
          wr_word = slpm_merge({19'h00000, s_q.gpio_dir, 3'h0, s_q.gpio_out},
                               s_q.wdata, s_q.wstrb);
          s_d.gpio_out = wr_word[`SLPM_GPIO_OUT_LSB +: 5];
          s_d.gpio_dir = wr_word[`SLPM_GPIO_DIR_LSB +: 5];
        end
        `SLPM_IDX_STAT: begin
          s_d.bresp = `SLPM_RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          s_d.bresp = `SLPM_RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_held;
    s_d.wready = !s_d.w_held;

    // Read decode
    case (s_axi_araddr_i[7:2])
      `SLPM_IDX_VINV: rd_word[7:0] = s_q.vinv_reg;
      `SLPM_IDX_PSAVE: rd_word[7:0] = s_q.psave_reg;
      `SLPM_IDX_PCFG: rd_word[7:0] = s_q.pcfg_reg;
      `SLPM_IDX_GPIO: begin
        rd_word[`SLPM_GPIO_OUT_LSB +: 5] = s_q.gpio_out;
        rd_word[`SLPM_GPIO_DIR_LSB +: 5] = s_q.gpio_dir;
      end
      `SLPM_IDX_STAT: begin
        rd_word[`SLPM_STAT_BUS_LSB +: 7] = s_q.host_bus;
        rd_word[`SLPM_STAT_BE_BIT] = s_q.big_endian;
        rd_word[`SLPM_STAT_STRAP_LSB +: 4] = s_q.strap_raw;
        rd_word[`SLPM_STAT_BS_BIT] = s_q.bs_raw;
        rd_word[`SLPM_STAT_GPIN_LSB +: 5] = s_q.gpio_in;
        rd_word[`SLPM_STAT_RUN_BIT] = (s_q.st == slpm_pkg::SLPM_ST_RUN);
      end
      default: rd_hit = 1'b0;
    endcase

    // Read channel: one read outstanding
    if (s_q.arready && s_axi_arvalid_i) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_hit ? `SLPM_RESP_OKAY : `SLPM_RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;

    // Pin inputs seen by software
    s_d.gpio_in = {panel_data_top_i, panel_data_mid_i, gp_io_zero_i};

    // Panel pins stay at their reset levels until the straps are taken
    if (s_q.st == slpm_pkg::SLPM_ST_RUN) begin
      s_d.pd_low = panel_data_i[7:0];
      s_d.frame = panel_frame_pulse_i;
      s_d.line = panel_line_pulse_i;
      s_d.shift = panel_shift_clock_i;
      s_d.pwr = s_q.pcfg_reg[`SLPM_PCFG_PWR_BIT];
      // Mid data pins
      if (active) begin
        s_d.mid_oe = 3'h7;
        s_d.mid_o = panel_data_i[10:8];
      end else begin
        s_d.mid_oe = s_q.gpio_dir[3:1];
        s_d.mid_o = s_q.gpio_out[3:1];
      end
      // Top data pin
      s_d.video_inv = 1'b0;
      if (active) begin
        s_d.top_oe = 1'b1;
        s_d.top_o = panel_data_i[11];
      end else if (s_q.vinv_reg[`SLPM_VINV_EN_BIT]) begin
        s_d.top_oe = 1'b0;
        s_d.top_o = 1'b0;
        s_d.video_inv = panel_data_top_i;
      end else begin
        s_d.top_oe = s_q.gpio_dir[4];
        s_d.top_o = s_q.gpio_out[4];
      end
      // Lowest general purpose pin
      if (s_q.psave_reg[`SLPM_PSAVE_SEL_BIT]) begin
        s_d.gp0_oe = 1'b0;
        s_d.gp0_o = 1'b0;
        s_d.power_save = gp_io_zero_i;
      end else begin
        s_d.gp0_oe = s_q.gpio_dir[0];
        s_d.gp0_o = s_q.gpio_out[0];
        s_d.power_save = 1'b0;
      end
      // Panel control pin
      case (s_q.pcfg_reg[1:0])
        slpm_pkg::SLPM_PK_ACTIVE: s_d.ctl = display_enable_i;
        slpm_pkg::SLPM_PK_COLOR_SHIFT2: s_d.ctl = panel_second_shift_clock_i;
        default: s_d.ctl = backplane_bias_i;
      endcase
    end
  end

  // ==========================================================
  // State register; reset forces defaults and inactive pins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign host_bus_o = s_q.host_bus;
  assign big_endian_o = s_q.big_endian;
  assign video_invert_o = s_q.video_inv;
  assign power_save_o = s_q.power_save;
  assign panel_data_low_o = s_q.pd_low;
  assign panel_data_mid_o = s_q.mid_o;
  assign panel_data_mid_oe_o = s_q.mid_oe;
  assign panel_data_top_o = s_q.top_o;
  assign panel_data_top_oe_o = s_q.top_oe;
  assign gp_io_zero_o = s_q.gp0_o;
  assign gp_io_zero_oe_o = s_q.gp0_oe;
  assign panel_frame_pulse_o = s_q.frame;
  assign panel_line_pulse_o = s_q.line;
  assign panel_shift_clock_o = s_q.shift;
  assign panel_ctl_out_o = s_q.ctl;
  assign panel_power_ctl_o = s_q.pwr;
  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o = s_q.wready;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;

  // ==========================================================
  // Assertions
  property p_sync_ready;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 (config_straps_i[2:0] == 3'h0) |=>
      (host_bus_o == slpm_pkg::SLPM_HB_SYNC_READY) && (big_endian_o == $past(config_straps_i[3]));
  endproperty
  a_sync_ready: assert property (p_sync_ready)
    else $error("sync ready bus not selected");

  property p_sync_wait;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 (config_straps_i[2:0] == 3'h1) |=>
      (host_bus_o == slpm_pkg::SLPM_HB_SYNC_WAIT) && (big_endian_o == $past(config_straps_i[3]));
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("sync wait bus not selected");

  property p_async_one;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 (config_straps_i == 4'hB) |=>
      (host_bus_o == slpm_pkg::SLPM_HB_ASYNC_ONE) && big_endian_o;
  endproperty
  a_async_one: assert property (p_async_one)
    else $error("first async bus not selected");

  property p_gen_one;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 (config_straps_i[2:0] == 3'h7) && !bus_start_n_i |=>
      (host_bus_o == slpm_pkg::SLPM_HB_GEN_ONE) && (big_endian_o == $past(config_straps_i[3]));
  endproperty
  a_gen_one: assert property (p_gen_one)
    else $error("generic one bus not selected");

  property p_gen_two;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 (config_straps_i == 4'h7) && bus_start_n_i |=>
      (host_bus_o == slpm_pkg::SLPM_HB_GEN_TWO) && !big_endian_o;
  endproperty
  a_gen_two: assert property (p_gen_two)
    else $error("generic two bus not selected");

  property p_bus_frozen;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.st == slpm_pkg::SLPM_ST_RUN) |=> $stable(host_bus_o) && $stable(big_endian_o);
  endproperty
  a_bus_frozen: assert property (p_bus_frozen)
    else $error("host bus changed after capture");

  property p_release_quiet;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !panel_power_ctl_o && (panel_data_low_o == 8'h00) &&
      (panel_data_mid_oe_o == 3'h0) && !panel_data_top_oe_o && !gp_io_zero_oe_o;
  endproperty
  a_release_quiet: assert property (p_release_quiet)
    else $error("output active straight after reset");

  property p_ctl_active;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.st == slpm_pkg::SLPM_ST_RUN) && (s_q.pcfg_reg[1:0] == 2'h3) |=>
      (panel_ctl_out_o == $past(display_enable_i)) && (panel_data_mid_oe_o == 3'h7);
  endproperty
  a_ctl_active: assert property (p_ctl_active)
    else $error("active panel control pin wrong");

  property p_ctl_shift2;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.st == slpm_pkg::SLPM_ST_RUN) && (s_q.pcfg_reg[1:0] == 2'h2) |=>
      panel_ctl_out_o == $past(panel_second_shift_clock_i);
  endproperty
  a_ctl_shift2: assert property (p_ctl_shift2)
    else $error("second shift clock not on control pin");

  property p_psave;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.st == slpm_pkg::SLPM_ST_RUN) && s_q.psave_reg[2] |=>
      !gp_io_zero_oe_o && (power_save_o == $past(gp_io_zero_i));
  endproperty
  a_psave: assert property (p_psave)
    else $error("power save pin not an input");

  property p_vinv;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.st == slpm_pkg::SLPM_ST_RUN) && s_q.vinv_reg[1] && (s_q.pcfg_reg[1:0] != 2'h3) |=>
      !panel_data_top_oe_o && (video_invert_o == $past(panel_data_top_i));
  endproperty
  a_vinv: assert property (p_vinv)
    else $error("video invert input not followed");

endmodule // slpm_top

// ---- verif/slpm_panel_model.sv ----
// Far-side pin model: resolves the shared panel pins with pull-ups
`timescale 1ns/1ps
module slpm_panel_model (
  input wire logic [2:0] mid_o_i,
  input wire logic [2:0] mid_oe_i,
  input wire logic top_o_i,
  input wire logic top_oe_i,
  input wire logic gp0_o_i,
  input wire logic gp0_oe_i,
  input wire logic [4:0] ext_val_i,
  input wire logic [4:0] ext_en_i,
  output logic [2:0] mid_lvl_o,
  output logic top_lvl_o,
  output logic gp0_lvl_o
);
  logic [4:0] oe, v, lvl;
  // =================================================
  // Wire level
  // Device drive wins, then the far side, else the pull-up
  assign oe = {top_oe_i, mid_oe_i, gp0_oe_i};
  assign v = {top_o_i, mid_o_i, gp0_o_i};
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      lvl[k] = oe[k] ? v[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
    end
  end
  assign {top_lvl_o, mid_lvl_o, gp0_lvl_o} = lvl;
endmodule // slpm_panel_model

// ---- verif/test_slpm_top.sv ----
// Self-checking bench of the strap decode and panel pin mux block
`timescale 1ns/1ps
module test_slpm_top;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, bus_start_n_i = 1'b0;
  logic [3:0] config_straps_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic [11:0] panel_data_i = 12'h000;
  logic panel_frame_pulse_i = 1'b0, panel_line_pulse_i = 1'b0, panel_shift_clock_i = 1'b0;
  logic panel_second_shift_clock_i = 1'b0, display_enable_i = 1'b0, backplane_bias_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [2:0] panel_data_mid_i, panel_data_mid_o, panel_data_mid_oe_o;
  logic panel_data_top_i, panel_data_top_o, panel_data_top_oe_o;
  logic gp_io_zero_i, gp_io_zero_o, gp_io_zero_oe_o;
  logic [7:0] panel_data_low_o, exp_st;
  logic panel_frame_pulse_o, panel_line_pulse_o, panel_shift_clock_o, panel_ctl_out_o;
  logic panel_power_ctl_o, big_endian_o, video_invert_o, power_save_o;
  slpm_pkg::slpm_host_bus_t host_bus_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [4:0] ext_val = 5'h00, ext_en = 5'h00;
  logic [31:0] mdl [0:63];
  logic [5:0] idx [6] = '{6'h02, 6'h03, 6'h10, 6'h11, 6'h12, 6'h20};
  int error_cnt = 0, num_checks = 0, cyc = 0, seed = 32'h93e6f94a;

  // =================================================
  // Design and far side
  slpm_top u_dut (.sys_clk_i, .rst_n_i, .config_straps_i, .bus_start_n_i, .panel_data_i,
    .panel_frame_pulse_i, .panel_line_pulse_i, .panel_shift_clock_i,
    .panel_second_shift_clock_i, .display_enable_i, .backplane_bias_i, .panel_data_low_o,
    .panel_data_mid_i, .panel_data_mid_o, .panel_data_mid_oe_o, .panel_data_top_i,
    .panel_data_top_o, .panel_data_top_oe_o, .gp_io_zero_i, .gp_io_zero_o, .gp_io_zero_oe_o,
    .panel_frame_pulse_o, .panel_line_pulse_o, .panel_shift_clock_o, .panel_ctl_out_o,
    .panel_power_ctl_o, .host_bus_o, .big_endian_o, .video_invert_o, .power_save_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i);
  slpm_panel_model u_far (.mid_o_i(panel_data_mid_o), .mid_oe_i(panel_data_mid_oe_o),
    .top_o_i(panel_data_top_o), .top_oe_i(panel_data_top_oe_o), .gp0_o_i(gp_io_zero_o),
    .gp0_oe_i(gp_io_zero_oe_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .mid_lvl_o(panel_data_mid_i), .top_lvl_o(panel_data_top_i), .gp0_lvl_o(gp_io_zero_i));

  // Clock and hang guard
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      test_done();
    end
  end

  // =================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Strap decode model: {big endian, one-hot bus}
  function automatic logic [7:0] dec(input logic [3:0] s, input logic b);
    case (s[2:0])
      3'h0: return {s[3], 7'h02};
      3'h1: return {s[3], 7'h04};
      3'h3: return s[3] ? 8'h88 : 8'h01;
      3'h5: return s[3] ? 8'h90 : 8'h01;
      3'h7: return !b ? {s[3], 7'h20} : (s[3] ? 8'h01 : 8'h40);
      default: return 8'h01;
    endcase
  endfunction

  // Writable bits of each place; zero means unmapped or read-only (12h)
  function automatic logic [31:0] msk(input logic [5:0] i);
    case (i)
      6'h02, 6'h03, 6'h10: return 32'h0000_00FF;
      6'h11: return 32'h0000_1F1F;
      default: return 32'h0;
    endcase
  endfunction

  // AXI4-Lite write: address and data together, response after both
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o === 1'b1) ad = 1;
      if (s_axi_wready_o === 1'b1) wd = 1;
      if (ad) s_axi_awvalid_i <= 1'b0;
      if (wd) s_axi_wvalid_i <= 1'b0;
    end while (!(ad && wd));
    do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  // AXI4-Lite read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic wreg(input logic [5:0] i, input logic [31:0] d);
    logic [1:0] r;
    axw({i, 2'h0}, d, r);
    if (msk(i) != 32'h0) mdl[i] = d & msk(i);
    chk("bresp", (msk(i) != 32'h0 || i == 6'h12) ? 2'h0 : 2'h2, r);
  endtask

  task automatic rreg(input logic [5:0] i);
    logic [31:0] d, e;
    logic [1:0] r;
    axr({i, 2'h0}, d, r);
    e = (i == 6'h12) ? {7'h00, 1'b1, 11'h000, 1'b1, 4'hF, exp_st} : mdl[i];
    chk("rdata", e, (i == 6'h12) ? (d & 32'h0100_1FFF) : d);
    chk("rresp", (msk(i) != 32'h0 || i == 6'h12) ? 2'h0 : 2'h2, r);
  endtask

  // Pin selection against the register model
  task automatic pin_chk();
    logic [1:0] k;
    logic [31:0] g, v, p;
    k = mdl[6'h10][1:0];
    g = mdl[6'h11];
    v = mdl[6'h02];
    p = mdl[6'h03];
    chk("low", panel_data_i[7:0], panel_data_low_o);
    chk("pulses", {panel_frame_pulse_i, panel_line_pulse_i, panel_shift_clock_i},
      {panel_frame_pulse_o, panel_line_pulse_o, panel_shift_clock_o});
    chk("power", mdl[6'h10][4], panel_power_ctl_o);
    chk("ctl", k == 2'h3 ? display_enable_i : (k == 2'h2 ? panel_second_shift_clock_i :
      backplane_bias_i), panel_ctl_out_o);
    if (k == 2'h3) begin
      chk("mid", {3'h7, panel_data_i[10:8]}, {panel_data_mid_oe_o, panel_data_mid_o});
      chk("top", {1'b1, panel_data_i[11]}, {panel_data_top_oe_o, panel_data_top_o});
    end else begin
      chk("mid", {g[11:9], g[3:1] & g[11:9]},
        {panel_data_mid_oe_o, panel_data_mid_o & panel_data_mid_oe_o});
      chk("top", {!v[1] && g[12], g[4] & g[12] & !v[1]},
        {panel_data_top_oe_o, panel_data_top_o & panel_data_top_oe_o});
    end
    chk("inv", (v[1] && k != 2'h3) ? panel_data_top_i : 1'b0, video_invert_o);
    chk("psave", p[2] ? gp_io_zero_i : 1'b0, power_save_o);
    chk("gp0", {!p[2] && g[8], g[0] & g[8] & !p[2]},
      {gp_io_zero_oe_o, gp_io_zero_o & gp_io_zero_oe_o});
  endtask

  // =================================================
  // Main sequence
  initial begin
    logic [7:0] e;
    for (int k = 0; k < 64; k++) mdl[k] = 32'h0;
    // Every strap and bus start pattern, straps moved after capture
    for (int c = 0; c < 32; c++) begin
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      config_straps_i <= c[3:0];
      bus_start_n_i <= c[4];
      panel_data_i <= 12'hFFF;
      {panel_frame_pulse_i, panel_line_pulse_i, panel_shift_clock_i} <= 3'h7;
      {panel_second_shift_clock_i, display_enable_i, backplane_bias_i} <= 3'h7;
      repeat (c == 0 ? 16 : 2) @(posedge sys_clk_i);
      #1 chk("rst outs", 32'h0, {panel_data_low_o, panel_frame_pulse_o, panel_line_pulse_o,
        panel_shift_clock_o, panel_ctl_out_o, panel_power_ctl_o, panel_data_mid_oe_o,
        panel_data_top_oe_o, gp_io_zero_oe_o, s_axi_awready_o,
        s_axi_arready_o});
      chk("rst bus", 7'h01, host_bus_o);
      @(posedge sys_clk_i) rst_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      config_straps_i <= ~c[3:0];
      bus_start_n_i <= ~c[4];
      e = dec(c[3:0], c[4]);
      repeat (3) @(posedge sys_clk_i);
      #1 chk("host bus", e[6:0], host_bus_o);
      chk("endian", e[7], big_endian_o);
      exp_st = e;
    end
    $display("test straps done");
    // Reset values, then write and read back, unmapped place included
    foreach (idx[k]) rreg(idx[k]);
    foreach (idx[k]) begin
      wreg(idx[k], $random(seed));
      rreg(idx[k]);
    end
    $display("test registers done");
    // Panel kinds in turn with random pins, registers and far-side drive
    for (int t = 0; t < 24; t++) begin
      wreg(6'h10, 32'(t % 4) | ($random(seed) & 32'h0000_0010));
      wreg(6'h11, $random(seed));
      wreg(6'h02, $random(seed));
      wreg(6'h03, $random(seed));
      panel_data_i <= 12'($random(seed));
      {panel_frame_pulse_i, panel_line_pulse_i, panel_shift_clock_i, panel_second_shift_clock_i,
        display_enable_i, backplane_bias_i} <= 6'($random(seed));
      ext_en <= 5'($random(seed));
      ext_val <= 5'($random(seed));
      repeat (4) @(posedge sys_clk_i);
      #1 pin_chk();
    end
    $display("test panel mux done");
    test_done();
  end
endmodule // test_slpm_top
